// ==== hdl/mwe_engine.v ====
`timescale 1ns/100ps
`include "mwe_defs.vh"

module mwe_fifo #(
  parameter WIDTH = `MWE_FIFO_WIDTH,
  parameter DEPTH = `MWE_FIFO_DEPTH,
  parameter AW = 3
) (
  input wire clk, // System clock
  input wire rst_n, // Async reset, active low
  input wire ce, // Clock enable
  input wire in_valid, // Write request
  output wire in_ready, // Room available
  input wire [WIDTH-1:0] in_data, // Write word
  output wire out_valid, // Word available
  input wire out_ready, // Read accept
  output wire [WIDTH-1:0] out_data // Head word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always @(posedge clk)
  begin
    if (ce && do_wr)
      mem[wr_ptr] <= in_data;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else if (ce)
    begin
      if (do_wr)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (do_wr && !do_rd)
        count <= count + 1'b1;
      else if (do_rd && !do_wr)
        count <= count - 1'b1;
    end
  end
endmodule

// Contract
// - Width pin high selects 16-bit words
// - Input bits sampled on rising serial clock
// - Output floats except read or status
// - Status low while busy, high ready
// - Output released on chip select fall
// - Start marker is first select-and-data-high edge; such edges are ignored while push_req is high
// - Nothing happens before a start marker
// - Select high leaves standby
// - Execute only after all bits arrive
// - 16-bit frame: 11 or 27 clocks
// - 8-bit frame: 12 or 20 clocks
// - Locked at power-up, refuses programming
// - Erase sets addressed word to ones
// - Low-voltage starts at select fall
// - Status only after select low gap
// - Start marker then select low clears status
// - Erase all sets array, self-timed
// - Self-timed cycles within their limits
// - Unlock persists until lock or power-off
// - Select low resets control, cycle finishes
// - Read sends zero then data word
module mwe_engine #(
  parameter WORD_LV_CYC = `MWE_WORD_LV_CYC,
  parameter WORD_HV_CYC = `MWE_WORD_HV_CYC,
  parameter ERASE_ALL_CYC = `MWE_ERASE_ALL_CYC,
  parameter WRITE_ALL_CYC = `MWE_WRITE_ALL_CYC
) (
  input wire clk, // System clock, 20 MHz
  input wire rst_n, // Async reset, power-up
  input wire ce, // Clock enable
  input wire cs, // Chip select pin
  input wire sclk, // Serial clock pin
  input wire di, // Serial data in pin
  input wire width_select_pin, // High: 16-bit words
  input wire fast_variant, // High: higher-voltage variant
  output reg do_out, // Serial data out
  output reg do_oe, // Data out drive enable
  output wire ready_busy_flag, // High when idle
  output wire locked, // Programming locked
  output wire cmd_stall // Command queue full
);
  localparam [1:0] S_WAIT = 2'h0;
  localparam [1:0] S_SHIFT = 2'h1;
  localparam [1:0] S_READ = 2'h2;
  localparam [1:0] S_DONE = 2'h3;
  localparam [1:0] X_IDLE = 2'h0;
  localparam [1:0] X_SWEEP = 2'h1;
  localparam [1:0] X_WAIT = 2'h2;
  localparam integer GAP_INT = `MWE_SELECT_LOW_GAP_CYC;
  localparam [2:0] GAP_CYC = GAP_INT[2:0];

  reg [7:0] mem [0:`MWE_ARRAY_BYTES-1];

  // Pin synchronisers
  reg [4:0] sync1;
  reg [4:0] sync2;
  reg cs_d;
  reg sclk_d;
  wire cs_s = sync2[0];
  wire sclk_s = sync2[1];
  wire di_s = sync2[2];
  wire wide = sync2[3];
  wire fast = sync2[4];
  wire rise = cs_s && sclk_s && !sclk_d;
  wire cs_fall = !cs_s && cs_d;
  wire cs_rise = cs_s && !cs_d;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      cs_d <= 1'b0;
      sclk_d <= 1'b0;
    end
    else if (ce)
    begin
      sync1 <= {fast_variant, width_select_pin, di, sclk, cs};
      sync2 <= sync1;
      cs_d <= cs_s;
      sclk_d <= sclk_s;
    end
  end

  // Frame decoder
  reg [1:0] sstate;
  reg [4:0] bitcnt;
  reg [25:0] sh;
  reg [1:0] op;
  reg [1:0] sub;
  reg [8:0] addr;
  reg [15:0] rsh;
  reg unlocked;
  reg pend;
  reg [1:0] pend_cmd;
  reg [15:0] pend_data;
  reg push_req;
  reg [`MWE_FIFO_WIDTH-1:0] push_word;
  reg armed;
  reg show;
  reg [2:0] low_cnt;
  wire fifo_in_ready;
  wire [25:0] next_sh = {sh[24:0], di_s};
  wire [4:0] nb = bitcnt + 5'h01;
  wire [4:0] hdr = wide ? `MWE_HDR_BITS_X16 : `MWE_HDR_BITS_X8;
  wire [4:0] dlen = wide ? `MWE_DATA_BITS_X16 : `MWE_DATA_BITS_X8;
  wire [1:0] h_op = wide ? next_sh[9:8] : next_sh[10:9];
  wire [1:0] h_sub = wide ? next_sh[7:6] : next_sh[8:7];
  wire [8:0] h_addr = wide ? {1'b0, next_sh[7:0]} : next_sh[8:0];
  wire [15:0] d_word = wide ? next_sh[15:0] : {8'h00, next_sh[7:0]};
  wire needs_data = (op == `MWE_OP_WRITE) || (op == `MWE_OP_EXT && sub == `MWE_SUB_WRALL);
  wire [15:0] rd_word = wide ? {mem[{h_addr[7:0], 1'b0}], mem[{h_addr[7:0], 1'b1}]}
    : {mem[h_addr], 8'h00};
  wire exec_ready;

  // Queue entry: fast, wide, cmd, addr, data
  task queue_cmd;
    input [1:0] cmd;
    input [15:0] data;
    begin
      if (unlocked)
      begin
        pend_cmd <= cmd;
        pend_data <= data;
        if (fast)
        begin
          push_req <= 1'b1;
          push_word <= {fast, wide, cmd, addr, data};
          armed <= 1'b1;
        end
        else
          pend <= 1'b1;
      end
    end
  endtask

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sstate <= S_WAIT;
      bitcnt <= 5'h00;
      sh <= 26'h0000000;
      op <= 2'h0;
      sub <= 2'h0;
      addr <= 9'h000;
      rsh <= 16'h0000;
      unlocked <= 1'b0;
      pend <= 1'b0;
      pend_cmd <= 2'h0;
      pend_data <= 16'h0000;
      push_req <= 1'b0;
      push_word <= {`MWE_FIFO_WIDTH{1'b0}};
      armed <= 1'b0;
      show <= 1'b0;
      low_cnt <= 3'h0;
      do_out <= 1'b0;
      do_oe <= 1'b0;
    end
    else if (ce)
    begin
      if (push_req && fifo_in_ready)
        push_req <= 1'b0;
      if (!cs_s)
      begin
        sstate <= S_WAIT;
        bitcnt <= 5'h00;
        do_oe <= 1'b0;
        show <= 1'b0;
        if (low_cnt != GAP_CYC)
          low_cnt <= low_cnt + 3'h1;
        if (cs_fall && pend && !push_req)
        begin
          pend <= 1'b0;
          push_req <= 1'b1;
          push_word <= {fast, wide, pend_cmd, addr, pend_data};
          armed <= 1'b1;
        end
        else if (cs_fall)
          pend <= 1'b0;
      end
      else
      begin
        low_cnt <= 3'h0;
        if (cs_rise && armed && low_cnt == GAP_CYC && sstate == S_WAIT)
        begin
          show <= 1'b1;
          do_oe <= 1'b1;
        end
        if (show)
          do_out <= exec_ready;
        if (rise)
        begin
          case (sstate)
            S_WAIT:
            begin
              if (di_s && !push_req)
              begin
                sstate <= S_SHIFT;
                bitcnt <= 5'h00;
                armed <= 1'b0;
                show <= 1'b0;
                do_oe <= 1'b0;
              end
            end
            S_SHIFT:
            begin
              sh <= next_sh;
              bitcnt <= nb;
              if (nb == hdr)
              begin
                op <= h_op;
                sub <= h_sub;
                addr <= h_addr;
                if (h_op == `MWE_OP_READ)
                begin
                  sstate <= S_READ;
                  rsh <= rd_word;
                  do_out <= 1'b0;
                  do_oe <= 1'b1;
                  bitcnt <= 5'h00;
                end
                else if (h_op == `MWE_OP_ERASE)
                begin
                  sstate <= S_DONE;
                  if (unlocked)
                  begin
                    pend_cmd <= `MWE_CMD_ERASE;
                    pend_data <= 16'hFFFF;
                    if (fast)
                    begin
                      push_req <= 1'b1;
                      push_word <= {fast, wide, `MWE_CMD_ERASE, h_addr, 16'hFFFF};
                      armed <= 1'b1;
                    end
                    else
                      pend <= 1'b1;
                  end
                end
                else if (h_op == `MWE_OP_EXT)
                begin
                  if (h_sub == `MWE_SUB_UNLOCK)
                  begin
                    unlocked <= 1'b1;
                    sstate <= S_DONE;
                  end
                  else if (h_sub == `MWE_SUB_LOCK)
                  begin
                    unlocked <= 1'b0;
                    sstate <= S_DONE;
                  end
                  else if (h_sub == `MWE_SUB_ERALL)
                  begin
                    sstate <= S_DONE;
                    if (unlocked)
                    begin
                      pend_cmd <= `MWE_CMD_ERALL;
                      pend_data <= 16'hFFFF;
                      if (fast)
                      begin
                        push_req <= 1'b1;
                        push_word <= {fast, wide, `MWE_CMD_ERALL, h_addr, 16'hFFFF};
                        armed <= 1'b1;
                      end
                      else
                        pend <= 1'b1;
                    end
                  end
                end
              end
              else if (nb == hdr + dlen && needs_data)
              begin
                sstate <= S_DONE;
                queue_cmd((op == `MWE_OP_WRITE) ? `MWE_CMD_WRITE : `MWE_CMD_WRALL, d_word);
              end
            end
            S_READ:
            begin
              do_out <= rsh[15];
              rsh <= {rsh[14:0], 1'b0};
              bitcnt <= nb;
              if (nb == dlen)
                sstate <= S_DONE;
            end
            default:
            begin
              sstate <= S_DONE;
            end
          endcase
        end
      end
    end
  end

  // Self-timed executor
  wire q_valid;
  wire [`MWE_FIFO_WIDTH-1:0] q_word;
  reg [1:0] xstate;
  reg [8:0] ptr;
  reg [8:0] last;
  reg [15:0] xdata;
  reg xwide;
  reg [19:0] timer;
  wire q_take = (xstate == X_IDLE);
  wire q_fast = q_word[28];
  wire q_wide = q_word[27];
  wire [1:0] q_cmd = q_word[26:25];
  wire [8:0] q_addr = q_word[24:16];
  wire whole = (q_cmd == `MWE_CMD_ERALL) || (q_cmd == `MWE_CMD_WRALL);
  wire [19:0] word_cyc = q_fast ? WORD_HV_CYC[19:0] : WORD_LV_CYC[19:0];
  wire [7:0] wval = (xwide && !ptr[0]) ? xdata[15:8] : xdata[7:0];

  assign exec_ready = (xstate == X_IDLE) && !q_valid && !push_req;
  assign ready_busy_flag = exec_ready;
  assign locked = !unlocked;
  assign cmd_stall = push_req && !fifo_in_ready;

  always @(posedge clk)
  begin
    if (ce && xstate == X_SWEEP)
      mem[ptr] <= wval;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xstate <= X_IDLE;
      ptr <= 9'h000;
      last <= 9'h000;
      xdata <= 16'h0000;
      xwide <= 1'b0;
      timer <= 20'h00000;
    end
    else if (ce)
    begin
      case (xstate)
        X_IDLE:
        begin
          if (q_valid)
          begin
            xstate <= X_SWEEP;
            xdata <= q_word[15:0];
            xwide <= q_wide;
            ptr <= whole ? 9'h000 : (q_wide ? {q_addr[7:0], 1'b0} : q_addr);
            last <= whole ? 9'h1FF : (q_wide ? {q_addr[7:0], 1'b1} : q_addr);
            case (q_cmd)
              `MWE_CMD_ERALL: timer <= ERASE_ALL_CYC[19:0];
              `MWE_CMD_WRALL: timer <= WRITE_ALL_CYC[19:0];
              default: timer <= word_cyc;
            endcase
          end
        end
        X_SWEEP:
        begin
          timer <= timer - 20'h00001;
          ptr <= ptr + 9'h001;
          if (ptr == last)
            xstate <= X_WAIT;
        end
        X_WAIT:
        begin
          timer <= timer - 20'h00001;
          if (timer <= 20'h00001)
            xstate <= X_IDLE;
        end
        default:
        begin
          xstate <= X_IDLE;
        end
      endcase
    end
  end

  mwe_fifo #(
    .WIDTH(`MWE_FIFO_WIDTH),
    .DEPTH(`MWE_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(push_req),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(q_valid),
    .out_ready(q_take),
    .out_data(q_word)
  );
endmodule

// ==== hdl/mwe_defs.vh ====
`ifndef MWE_DEFS_VH
`define MWE_DEFS_VH

// Clock and timing figures
`define MWE_CLK_NS 50
`define MWE_SELECT_LOW_GAP_NS 250
`define MWE_T_WORD_LV_NS 6000000
`define MWE_T_WORD_HV_NS 2000000
`define MWE_ARRAY_ERASE_TIME_NS 6000000
`define MWE_ARRAY_WRITE_TIME_NS 15000000
`define MWE_SELECT_LOW_GAP_CYC ((`MWE_SELECT_LOW_GAP_NS + `MWE_CLK_NS - 1) / `MWE_CLK_NS)
`define MWE_WORD_LV_CYC (`MWE_T_WORD_LV_NS / `MWE_CLK_NS)
`define MWE_WORD_HV_CYC (`MWE_T_WORD_HV_NS / `MWE_CLK_NS)
`define MWE_ERASE_ALL_CYC (`MWE_ARRAY_ERASE_TIME_NS / `MWE_CLK_NS)
`define MWE_WRITE_ALL_CYC (`MWE_ARRAY_WRITE_TIME_NS / `MWE_CLK_NS)

// Frame layout, bits after the start marker
`define MWE_HDR_BITS_X16 5'h0A
`define MWE_HDR_BITS_X8 5'h0B
`define MWE_DATA_BITS_X16 5'h10
`define MWE_DATA_BITS_X8 5'h08

// Serial opcodes
`define MWE_OP_EXT 2'h0
`define MWE_OP_WRITE 2'h1
`define MWE_OP_READ 2'h2
`define MWE_OP_ERASE 2'h3
// Extended sub-codes (top two address bits)
`define MWE_SUB_LOCK 2'h0
`define MWE_SUB_WRALL 2'h1
`define MWE_SUB_ERALL 2'h2
`define MWE_SUB_UNLOCK 2'h3

// Queued programming commands
`define MWE_CMD_ERASE 2'h0
`define MWE_CMD_ERALL 2'h1
`define MWE_CMD_WRITE 2'h2
`define MWE_CMD_WRALL 2'h3

`define MWE_FIFO_WIDTH 29
`define MWE_FIFO_DEPTH 8
`define MWE_ARRAY_BYTES 512

`endif

// ==== sim/mwe_engine_assertions.sv ====
`timescale 1ns/100ps
`include "mwe_defs.vh"
module mwe_engine_assertions #(
  parameter WRITE_ALL_CYC = `MWE_WRITE_ALL_CYC
) (
  input wire clk, // Clock
  input wire rst_n, // Reset
  input wire ce, // Enable
  input wire cs, // Select
  input wire do_out, // Serial out
  input wire do_oe, // Out enable
  input wire ready_busy_flag, // Idle
  input wire locked, // Lock state
  input wire cmd_stall // Queue full
);
  int busy_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_cs_idle;
    !cs [*6];
  endsequence
  sequence s_ce_held;
    !ce ##1 !ce;
  endsequence
  // Length of the current busy stretch
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_cnt <= 0;
    else if (ready_busy_flag)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end
  a_reset_state: assert property ($rose(rst_n) |-> locked && ready_busy_flag && !do_oe)
    else $error("wrong state after reset");
  a_oe_idle: assert property (s_cs_idle |-> !do_oe)
    else $error("data out driven while deselected");
  a_oe_drop: assert property ($fell(cs) |-> ##[1:6] !do_oe)
    else $error("data out not released after select fall");
  a_lock_steady: assert property (s_cs_idle |=> $stable(locked))
    else $error("lock changed while deselected");
  a_lock_no_oe: assert property ($changed(locked) |-> !do_oe [*4])
    else $error("data out driven by lock change");
  a_busy_min: assert property ($fell(ready_busy_flag) |-> !ready_busy_flag [*8])
    else $error("busy too short");
  a_cycle_bound: assert property (busy_cnt <= 12 * WRITE_ALL_CYC)
    else $error("busy too long");
  a_stall_busy: assert property (cmd_stall |-> !ready_busy_flag)
    else $error("stall while idle");
  a_ce_freeze: assert property (s_ce_held |-> $stable(locked) && $stable(ready_busy_flag))
    else $error("state moved while frozen");
endmodule
bind mwe_engine mwe_engine_assertions #(.WRITE_ALL_CYC(WRITE_ALL_CYC)) u_chk (.clk(clk),
  .rst_n(rst_n), .ce(ce), .cs(cs), .do_out(do_out), .do_oe(do_oe),
  .ready_busy_flag(ready_busy_flag), .locked(locked), .cmd_stall(cmd_stall));

// ==== sim/mwe_master.sv ====
`timescale 1ns/100ps
module mwe_master (
  input wire logic clk, // Bench clock
  input wire logic do_line, // Resolved data out
  output logic cs, // Chip select
  output logic sclk, // Serial clock
  output logic di // Serial data in
);
  initial
  begin
    cs = 0;
    sclk = 0;
    di = 0;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task sel(input int n);
    sclk = 0;
    di = 0;
    cs = 1;
    tick(n);
  endtask
  // Bits MSB first; got collects data out before each rise and once after
  task frame(input logic [26:0] f, input int n, output logic [27:0] got);
    int i;
    got = '0;
    if (cs !== 1'b1)
      sel(2);
    for (i = n - 1; i >= 0; i--)
    begin
      di = f[i];
      tick(4);
      got = {got[26:0], do_line};
      sclk = 1;
      tick(4);
      sclk = 0;
    end
    tick(4);
    got = {got[26:0], do_line};
  endtask
  task gap(input int n);
    cs = 0;
    tick(n);
  endtask
endmodule

// ==== sim/mwe_engine_tb.sv ====
`timescale 1ns/100ps
module mwe_engine_tb;
  typedef struct {logic ws; int n; logic [26:0] f; logic lk;} mwe_row_t;
  logic clk;
  logic rst_n;
  logic ce;
  logic ws;
  logic fast;
  logic seen;
  wire do_out, do_oe, rbf, locked, cmd_stall, cs, sclk, di;
  wire do_line = do_oe ? do_out : 1'bz;
  logic [27:0] got;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int k;
  // Width, bit count, frame, lock state expected after it
  mwe_row_t rows [8] = '{
    '{1'b1, 11, 27'h4C0, 1'b0}, '{1'b1, 11, 27'h400, 1'b1},
    '{1'b0, 12, 27'h980, 1'b0}, '{1'b0, 12, 27'h800, 1'b1},
    '{1'b1, 10, 27'h260, 1'b1}, '{1'b0, 11, 27'h4C0, 1'b1},
    '{1'b1, 13, 27'h4C0, 1'b0}, '{1'b1, 11, 27'h400, 1'b1}};
  initial
  begin
    clk = 0;
    rst_n = 0;
    ce = 1;
    ws = 1;
    fast = 0;
    seen = 0;
  end
  always #25 clk = ~clk;
  mwe_engine #(.WORD_LV_CYC(600), .WORD_HV_CYC(600), .ERASE_ALL_CYC(600),
    .WRITE_ALL_CYC(600)) dut (.clk(clk), .rst_n(rst_n), .ce(ce), .cs(cs), .sclk(sclk),
    .di(di), .width_select_pin(ws), .fast_variant(fast), .do_out(do_out), .do_oe(do_oe),
    .ready_busy_flag(rbf), .locked(locked), .cmd_stall(cmd_stall));
  mwe_master m (.clk(clk), .do_line(do_line), .cs(cs), .sclk(sclk), .di(di));
  task end_of_test;
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      end_of_test();
    end
  end
  task chk(input logic [15:0] seen_v, input logic [15:0] exp);
    n_tests++;
    if (seen_v !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen_v, exp);
    end
  endtask
  task done_t(input string s);
    $display("test %s finished", s);
  endtask
  task cmd(input logic [26:0] f, input int n);
    m.frame(f, n, got);
    m.gap(8);
  endtask
  task wait_ready(input int lim);
    int i;
    for (i = 0; i < lim && rbf !== 1'b1; i++)
      m.tick(1);
    chk(rbf, 1'b1);
  endtask
  initial
  begin
    m.tick(8);
    rst_n = 1;
    chk(locked, 1'b1);
    chk(rbf, 1'b1);
    chk(do_oe, 1'b0);
    chk(cmd_stall, 1'b0);
    done_t("reset");
    m.tick(3);
    for (k = 0; k < 8; k++)
    begin
      ws = rows[k].ws;
      m.tick(4);
      cmd(rows[k].f, rows[k].n);
      chk(locked, rows[k].lk);
      chk(do_oe, 1'b0);
      chk(rbf, 1'b1);
    end
    done_t("table");
    ws = 1;
    m.tick(4);
    cmd(27'h705, 11);
    chk(rbf, 1'b1);
    cmd(27'h4C0, 11);
    cmd(27'h5051234, 27);
    wait_ready(700);
    cmd(27'h6050000, 27);
    chk(got[16], 1'b0);
    chk(got[15:0], 16'h1234);
    done_t("write read");
    m.frame(27'h705, 11, got);
    chk(rbf, 1'b1);
    m.gap(8);
    chk(rbf, 1'b0);
    m.sel(8);
    chk(do_oe, 1'b1);
    chk(do_out, 1'b0);
    m.tick(700);
    chk(do_out, 1'b1);
    chk(locked, 1'b0);
    m.frame(27'h1, 1, got);
    m.gap(8);
    chk(do_oe, 1'b0);
    m.sel(8);
    chk(do_oe, 1'b0);
    m.gap(8);
    cmd(27'h6050000, 27);
    chk(got[15:0], 16'hFFFF);
    done_t("erase");
    ws = 0;
    fast = 1;
    m.tick(4);
    m.frame(27'h900, 12, got);
    chk(rbf, 1'b0);
    ce = 0;
    m.tick(10);
    chk(rbf, 1'b0);
    ce = 1;
    m.gap(8);
    wait_ready(700);
    cmd(27'hC0900, 20);
    chk(got[8], 1'b0);
    chk(got[7:0], 16'h00FF);
    done_t("erase all");
    cmd(27'h880A5, 20);
    wait_ready(700);
    cmd(27'hC0900, 20);
    chk(got[7:0], 16'h00A5);
    done_t("write all");
    ws = 1;
    fast = 0;
    m.tick(4);
    repeat (12)
    begin
      m.frame(27'h705, 11, got);
      m.gap(6);
      seen = seen | cmd_stall;
    end
    chk(seen, 1'b1);
    wait_ready(9000);
    done_t("queue");
    end_of_test();
  end
endmodule
